// ### inc/vpoh_consts.svh
/*
 register offsets, reset values and field positions of the transmit path overhead block.
 assumes a byte-wide register port with 16-bit addresses.
*/
`ifndef VPOH_CONSTS_SVH
`define VPOH_CONSTS_SVH
`define VPOH_OFS_CTRL1      16'h1982
`define VPOH_OFS_CTRL0      16'h1983
`define VPOH_OFS_TRACE      16'h1993
`define VPOH_OFS_PARMASK    16'h1997
`define VPOH_OFS_SIGLABEL   16'h199B
`define VPOH_OFS_PSTATUS    16'h199F
`define VPOH_OFS_USERCH     16'h19A3
`define VPOH_OFS_MFIND      16'h19A7
`define VPOH_OFS_Z3         16'h19AB
`define VPOH_OFS_Z4         16'h19AF
`define VPOH_OFS_Z5         16'h19B3
`define VPOH_OFS_TXCTRL     16'h19B7
`define VPOH_OFS_TRACECTRL  16'h19BB
`define VPOH_OFS_APTRH      16'h19BF
`define VPOH_OFS_APTRL      16'h19C3
`define VPOH_OFS_PTR1       16'h19C6
`define VPOH_OFS_PTR0       16'h19C7
`define VPOH_OFS_RDI2       16'h19C9
`define VPOH_OFS_RDI1       16'h19CA
`define VPOH_OFS_RDI0       16'h19CB
`define VPOH_OFS_SERCTRL    16'h19CF
`define VPOH_RST_ZERO       8'h00
`define VPOH_RST_APTRH      8'h94
`define VPOH_RST_APTRL      8'h00
`define VPOH_RST_PTR1       8'h02
`define VPOH_RST_PTR0       8'h0A
`define VPOH_RST_RDI2       8'h40
`define VPOH_RST_RDI1       8'hC0
`define VPOH_RST_RDI0       8'hA0
`define VPOH_CTRL1_MASK     8'h0F
`define VPOH_BIT_H4         0
`define VPOH_BIT_Z3         1
`define VPOH_BIT_Z4         2
`define VPOH_BIT_Z5         3
`endif

// ### inc/vpoh_pkg.sv
/*
 types of the transmit path overhead block.
 assumes vpoh_consts.svh is on the include path.
*/
package vpoh_pkg;
	typedef enum logic [1:0] {
		VPOH_SEL_H4,
		VPOH_SEL_Z3,
		VPOH_SEL_Z4,
		VPOH_SEL_Z5
	} vpoh_sel_type;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} vpoh_bus_req_type;

	typedef struct packed {
		logic       valid;
		logic [1:0] sel;
		logic [7:0] data;
	} vpoh_ohb_type;

	typedef struct packed {
		logic [7:0] ctrl1;
		logic [7:0] ctrl0;
		logic [7:0] trace;
		logic [7:0] parmask;
		logic [7:0] siglabel;
		logic [7:0] pstatus;
		logic [7:0] userch;
		logic [7:0] mfind;
		logic [7:0] z3;
		logic [7:0] z4;
		logic [7:0] z5;
		logic [7:0] txctrl;
		logic [7:0] tracectrl;
		logic [7:0] aptrh;
		logic [7:0] aptrl;
		logic [7:0] ptr1;
		logic [7:0] ptr0;
		logic [7:0] rdi2;
		logic [7:0] rdi1;
		logic [7:0] rdi0;
		logic [7:0] serctrl;
	} vpoh_regs_type;
endpackage

// ### hw/vpoh_fifo.sv
/*
 small synchronous fifo with valid/ready on both sides.
 assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module vpoh_fifo
	import vpoh_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	// pointers wrap by overflow, so only powers of two are served
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_bad
		$error("depth must be a power of two");
	end
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} vpoh_fifo_st_type;
	vpoh_fifo_st_type st, next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;
	always_comb begin
		in_ready  = (st.wp - st.rp) != (AW+1)'(DEPTH);
		out_valid = st.wp != st.rp;
		out_data  = mem[st.rp[AW-1:0]];
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		next_st   = st;
		if (push)
			next_st.wp = st.wp + 1'b1;
		if (pop)
			next_st.rp = st.rp + 1'b1;
	end
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			st <= '0;
		else
			st <= next_st;
		if (push)
			mem[st.wp[AW-1:0]] <= in_data;
	end
endmodule // vpoh_fifo

// ### hw/vpoh_insert.sv
/*
 transmit path overhead insertion: register map and per-frame source choice for h4, z3, z4, z5.
 assumes a byte-wide register port, a frame start pulse and a byte slot request from the framer,
 and an external overhead source that pushes bytes into a fifo ahead of need.
*/
`timescale 1ns/1ns
`include "vpoh_consts.svh"
module vpoh_insert
	import vpoh_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// register port
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	// mode
	input  wire logic       tug3_mode,
	// frame timing
	input  wire logic       frame_start,
	input  wire logic       slot_req,
	input  wire logic [1:0] slot_sel,
	// external overhead input
	input  wire logic       ext_path_overhead_valid,
	output logic            ext_path_overhead_ready,
	input  wire logic [7:0] ext_path_overhead_in,
	// overhead byte out
	output logic            ohb_valid,
	output logic      [1:0] ohb_sel,
	output logic      [7:0] ohb_data,
	output logic            ohb_underrun
);
	localparam int FW = $clog2(FIFO_DEPTH) + 1;
	// the fifo pointers wrap by overflow, so only powers of two work
	if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin : g_depth_bad
		$error("fifo depth must be a power of two");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		vpoh_regs_type regs;
		logic [3:0]    act_src;
		logic [31:0]   act_val;
		logic          active;
		logic          mode_q1;
		logic          mode_q2;
		logic          mode_q3;
		logic [7:0]    rdata;
		logic          rvalid;
		vpoh_ohb_type  ohb;
		logic          under;
		logic [FW-1:0] fill;
		logic          ext_rdy;
	} vpoh_st_type;
	vpoh_st_type st, next_st;

	logic       f_valid;
	logic       f_ready;
	logic [7:0] f_data;
	logic       f_push;

	// external bytes are buffered so a bursty source still meets each slot
	vpoh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.in_valid  (f_push),
		.in_ready  (),
		.in_data   (ext_path_overhead_in),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	// ----------------------------------------
	// register read decode
	// ----------------------------------------
	function automatic logic [7:0] read_reg(input vpoh_regs_type r, input logic [15:0] a);
		case (a)
			`VPOH_OFS_CTRL1:     read_reg = r.ctrl1;
			`VPOH_OFS_CTRL0:     read_reg = r.ctrl0;
			`VPOH_OFS_TRACE:     read_reg = r.trace;
			`VPOH_OFS_PARMASK:   read_reg = r.parmask;
			`VPOH_OFS_SIGLABEL:  read_reg = r.siglabel;
			`VPOH_OFS_PSTATUS:   read_reg = r.pstatus;
			`VPOH_OFS_USERCH:    read_reg = r.userch;
			`VPOH_OFS_MFIND:     read_reg = r.mfind;
			`VPOH_OFS_Z3:        read_reg = r.z3;
			`VPOH_OFS_Z4:        read_reg = r.z4;
			`VPOH_OFS_Z5:        read_reg = r.z5;
			`VPOH_OFS_TXCTRL:    read_reg = r.txctrl;
			`VPOH_OFS_TRACECTRL: read_reg = r.tracectrl;
			`VPOH_OFS_APTRH:     read_reg = r.aptrh;
			`VPOH_OFS_APTRL:     read_reg = r.aptrl;
			`VPOH_OFS_PTR1:      read_reg = r.ptr1;
			`VPOH_OFS_PTR0:      read_reg = r.ptr0;
			`VPOH_OFS_RDI2:      read_reg = r.rdi2;
			`VPOH_OFS_RDI1:      read_reg = r.rdi1;
			`VPOH_OFS_RDI0:      read_reg = r.rdi0;
			`VPOH_OFS_SERCTRL:   read_reg = r.serctrl;
			default:             read_reg = 8'h00;
		endcase
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic       use_ext;
	logic [7:0] reg_byte;
	always_comb begin
		next_st = st;
		f_ready = 1'b0;
		f_push  = ext_path_overhead_valid && st.ext_rdy;
		use_ext = 1'b0;
		reg_byte = 8'h00;

		// mode strap from another domain: three stages, second and third must agree
		next_st.mode_q1 = tug3_mode;
		next_st.mode_q2 = st.mode_q1;
		next_st.mode_q3 = st.mode_q2;
		if (st.mode_q2 == st.mode_q3)
			next_st.active = st.mode_q3;

		// register writes; reserved addresses fall through untouched
		if (reg_wr) begin
			case (reg_addr)
				`VPOH_OFS_CTRL1:     next_st.regs.ctrl1     = reg_wdata & `VPOH_CTRL1_MASK;
				`VPOH_OFS_CTRL0:     next_st.regs.ctrl0     = reg_wdata & 8'hFD;
				`VPOH_OFS_TRACE:     next_st.regs.trace     = reg_wdata;
				`VPOH_OFS_PARMASK:   next_st.regs.parmask   = reg_wdata;
				`VPOH_OFS_SIGLABEL:  next_st.regs.siglabel  = reg_wdata;
				`VPOH_OFS_PSTATUS:   next_st.regs.pstatus   = reg_wdata;
				`VPOH_OFS_USERCH:    next_st.regs.userch    = reg_wdata;
				`VPOH_OFS_MFIND:     next_st.regs.mfind     = reg_wdata;
				`VPOH_OFS_Z3:        next_st.regs.z3        = reg_wdata;
				`VPOH_OFS_Z4:        next_st.regs.z4        = reg_wdata;
				`VPOH_OFS_Z5:        next_st.regs.z5        = reg_wdata;
				`VPOH_OFS_TXCTRL:    next_st.regs.txctrl    = reg_wdata;
				`VPOH_OFS_TRACECTRL: next_st.regs.tracectrl = reg_wdata;
				`VPOH_OFS_APTRH:     next_st.regs.aptrh     = reg_wdata;
				`VPOH_OFS_APTRL:     next_st.regs.aptrl     = reg_wdata;
				`VPOH_OFS_PTR1:      next_st.regs.ptr1      = reg_wdata;
				`VPOH_OFS_PTR0:      next_st.regs.ptr0      = reg_wdata;
				`VPOH_OFS_RDI2:      next_st.regs.rdi2      = reg_wdata;
				`VPOH_OFS_RDI1:      next_st.regs.rdi1      = reg_wdata;
				`VPOH_OFS_RDI0:      next_st.regs.rdi0      = reg_wdata;
				`VPOH_OFS_SERCTRL:   next_st.regs.serctrl   = reg_wdata;
				default:             next_st.regs           = st.regs;
			endcase
		end

		// read answers one cycle after the strobe
		next_st.rvalid = reg_rd;
		next_st.rdata  = reg_rd ? read_reg(st.regs, reg_addr) : 8'h00;

		// shadow copies load only on a frame boundary, so a byte is never half new
		if (frame_start) begin
			next_st.act_src = st.regs.ctrl1[3:0];
			next_st.act_val = {st.regs.z5, st.regs.z4, st.regs.z3, st.regs.mfind};
		end

		// slot service
		next_st.ohb.valid = 1'b0;
		next_st.ohb.sel   = st.ohb.sel;
		next_st.ohb.data  = st.ohb.data;
		next_st.under     = 1'b0;
		if (st.active && slot_req) begin
			use_ext = st.act_src[slot_sel];
			case (slot_sel)
				2'h0:    reg_byte = st.act_val[7:0];
				2'h1:    reg_byte = st.act_val[15:8];
				2'h2:    reg_byte = st.act_val[23:16];
				2'h3:    reg_byte = st.act_val[31:24];
				default: reg_byte = 8'h00;
			endcase
			next_st.ohb.valid = 1'b1;
			next_st.ohb.sel   = slot_sel;
			if (use_ext) begin
				f_ready          = 1'b1;
				next_st.ohb.data = f_valid ? f_data : 8'h00;
				next_st.under    = !f_valid;
			end else begin
				next_st.ohb.data = reg_byte;
			end
		end
		// own fill count, so ready is exact in the very cycle the source sees it
		next_st.fill    = st.fill + FW'(f_push) - FW'(f_ready && f_valid);
		next_st.ext_rdy = next_st.fill < FW'(FIFO_DEPTH);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			st                <= '0;
			st.regs.aptrh     <= `VPOH_RST_APTRH;
			st.regs.aptrl     <= `VPOH_RST_APTRL;
			st.regs.ptr1      <= `VPOH_RST_PTR1;
			st.regs.ptr0      <= `VPOH_RST_PTR0;
			st.regs.rdi2      <= `VPOH_RST_RDI2;
			st.regs.rdi1      <= `VPOH_RST_RDI1;
			st.regs.rdi0      <= `VPOH_RST_RDI0;
		end else begin
			st <= next_st;
		end
	end

	// all outputs straight from the state register
	always_comb begin
		reg_rdata               = st.rdata;
		reg_rvalid              = st.rvalid;
		ohb_valid               = st.ohb.valid;
		ohb_sel                 = st.ohb.sel;
		ohb_data                = st.ohb.data;
		ohb_underrun            = st.under;
		ext_path_overhead_ready = st.ext_rdy;
	end
endmodule // vpoh_insert

// ### dv/vpoh_insert_asserts.sv
/*
 checker for vpoh_insert: register answers and overhead slot output.
 assumes it is bound to vpoh_insert and sees one clock domain.
*/
`timescale 1ns/1ns
module vpoh_asserts (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        reset_n,
	// register port
	input wire logic        reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_rvalid,
	// slots and source
	input wire logic        tug3_mode,
	input wire logic        slot_req,
	input wire logic [1:0]  slot_sel,
	input wire logic        ext_path_overhead_ready,
	input wire logic        ohb_valid,
	input wire logic [1:0]  ohb_sel,
	input wire logic [7:0]  ohb_data,
	input wire logic        ohb_underrun
);
	// ----
	// properties
	// ----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
	answer_cause_a: assert property (reg_rvalid |-> $past(reg_rd)) else $error("answer without read");
	idle_rdata_a: assert property (!reg_rvalid |-> reg_rdata == 8'h00) else $error("read data not idle");
	reserved_zero_a: assert property (reg_rd && (reg_addr == 16'h19C8 || reg_addr > 16'h19CF)
		|=> reg_rdata == 8'h00) else $error("reserved read not zero");
	slot_cause_a: assert property (ohb_valid |-> $past(slot_req) && ohb_sel == $past(slot_sel))
		else $error("overhead byte without slot");
	au3_quiet_a: assert property (!tug3_mode [*8] ##0 slot_req |=> !ohb_valid)
		else $error("overhead byte in au-3 mode");
	underrun_zero_a: assert property (ohb_underrun |-> ohb_valid && ohb_data == 8'h00)
		else $error("underrun byte not zero");
	ready_release_a: assert property ($rose(reset_n) |-> ##[0:2] ext_path_overhead_ready)
		else $error("source not ready after reset");
endmodule // vpoh_asserts

bind vpoh_insert vpoh_asserts chk_u (.ref_clk(ref_clk), .reset_n(reset_n), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .tug3_mode(tug3_mode),
	.slot_req(slot_req), .slot_sel(slot_sel), .ext_path_overhead_ready(ext_path_overhead_ready),
	.ohb_valid(ohb_valid), .ohb_sel(ohb_sel), .ohb_data(ohb_data), .ohb_underrun(ohb_underrun));

// ### dv/vpoh_ext_src.sv
/*
 external overhead source: pushes queued bytes over valid/ready.
 assumes the bench fills pend; one byte is offered at a time.
*/
`timescale 1ns/1ns
module vpoh_ext_src (
	// clock
	input  wire logic       ref_clk,
	// handshake
	input  wire logic       ready,
	output logic            valid,
	output logic      [7:0] data
);
	logic [7:0] pend [$];
	// held until taken; a released line shows the inverse, never a stale byte
	initial begin
		valid = 1'b0;
		data  = 8'h00;
		forever begin
			@(posedge ref_clk);
			if (valid && ready) begin
				valid <= 1'b0;
				data  <= ~data;
			end else if (!valid && pend.size() > 0) begin
				valid <= 1'b1;
				data  <= pend.pop_front();
			end
		end
	end
endmodule // vpoh_ext_src

// ### dv/vc4_path_overhead_insert_bench.sv
/*
 bench for vpoh_insert: register map, overhead sources, fifo fill and drain.
 assumes the checker is bound and vpoh_ext_src stands at the external input.
*/
`timescale 1ns/1ns
`include "vpoh_consts.svh"
module vc4_path_overhead_insert_bench import vpoh_pkg::*;;
	logic        ref_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        tug3_mode = 1'b1, frame_start = 1'b0, slot_req = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata, ohb_data, src_data, d;
	logic [1:0]  slot_sel = 2'h0, ohb_sel;
	logic        reg_rvalid, src_valid, src_ready, ohb_valid, ohb_underrun;
	int          fail_count = 0, checks = 0, i;
	// address, reset value, readable mask
	logic [31:0] rows [23] = '{32'h1982_000F, 32'h1983_00FD, 32'h1993_00FF, 32'h1997_00FF, 32'h199B_00FF,
		32'h199F_00FF, 32'h19A3_00FF, 32'h19A7_00FF, 32'h19AB_00FF, 32'h19AF_00FF, 32'h19B3_00FF,
		32'h19B7_00FF, 32'h19BB_00FF, 32'h19BF_94FF, 32'h19C3_00FF, 32'h19C6_02FF, 32'h19C7_0AFF,
		32'h19C9_40FF, 32'h19CA_C0FF, 32'h19CB_A0FF, 32'h19CF_00FF, 32'h19C8_0000, 32'h19D0_0000};

	vpoh_insert dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.tug3_mode(tug3_mode), .frame_start(frame_start), .slot_req(slot_req), .slot_sel(slot_sel),
		.ext_path_overhead_valid(src_valid), .ext_path_overhead_ready(src_ready),
		.ext_path_overhead_in(src_data), .ohb_valid(ohb_valid), .ohb_sel(ohb_sel),
		.ohb_data(ohb_data), .ohb_underrun(ohb_underrun));
	vpoh_ext_src src_u (.ref_clk(ref_clk), .ready(src_ready), .valid(src_valid), .data(src_data));

	initial forever #50 ref_clk = ~ref_clk;

	// ----
	// tasks
	// ----
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
		check("reg_rvalid", {7'h00, reg_rvalid}, 8'h01);
	endtask
	task automatic frame();
		@(posedge ref_clk);
		frame_start <= 1'b1;
		@(posedge ref_clk);
		frame_start <= 1'b0;
	endtask
	// v low: the slot must be ignored
	task automatic slot(input logic [1:0] s, input logic [7:0] e, input logic v);
		@(posedge ref_clk);
		slot_req <= 1'b1;
		slot_sel <= s;
		@(posedge ref_clk);
		slot_req <= 1'b0;
		#1;
		check("ohb_valid", {7'h00, ohb_valid}, {7'h00, v});
		if (v) begin
			check("ohb_sel", {6'h00, ohb_sel}, {6'h00, s});
			check("ohb_data", ohb_data, e);
		end
	endtask

	// ----
	// sequence
	// ----
	initial begin
		repeat (3000) @(posedge ref_clk);
		fail_count++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		foreach (rows[k]) begin
			rd(rows[k][31:16], d);
			check("reset value", d, rows[k][15:8]);
			wr(rows[k][31:16], 8'h5A);
			rd(rows[k][31:16], d);
			check("readback", d, 8'h5A & rows[k][7:0]);
		end
		for (i = 0; i < 4; i++)
			wr(`VPOH_OFS_MFIND + 16'(4 * i), 8'(8'h11 * (i + 1)));
		wr(`VPOH_OFS_CTRL1, 8'h00);
		frame();
		for (i = 0; i < 4; i++)
			slot(2'(i), 8'(8'h11 * (i + 1)), 1'b1);
		wr(`VPOH_OFS_CTRL1, 8'h0F);
		frame();
		for (i = 0; i < 4; i++)
			src_u.pend.push_back(8'(8'hC0 + i));
		repeat (12) @(posedge ref_clk);
		for (i = 0; i < 4; i++)
			slot(2'(i), 8'(8'hC0 + i), 1'b1);
		// one more than the fifo holds, so the source is refused and stalls
		for (i = 0; i < 17; i++)
			src_u.pend.push_back(8'(8'h80 + i));
		repeat (40) @(posedge ref_clk);
		#1;
		check("fifo ready", {7'h00, src_ready}, 8'h00);
		for (i = 0; i < 17; i++) begin
			if (i == 1)
				wr(`VPOH_OFS_CTRL1, 8'h00);
			slot(2'(i), 8'(8'h80 + i), 1'b1);
		end
		slot(2'h3, 8'h00, 1'b1);
		check("underrun", {7'h00, ohb_underrun}, 8'h01);
		frame();
		slot(2'h3, 8'h44, 1'b1);
		@(posedge ref_clk);
		tug3_mode <= 1'b0;
		repeat (8) @(posedge ref_clk);
		slot(2'h0, 8'h00, 1'b0);
		wrap_up();
	end
endmodule // vc4_path_overhead_insert_bench
